// *** rtl/alu_pkg.sv ***
package alu_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] ACC_OFF   = 8'h04;
  localparam logic [7:0] FLAG_OFF  = 8'h08;
  localparam logic [7:0] MADDR_OFF = 8'h0C;
  localparam logic [7:0] MDATA_OFF = 8'h10;

  // Command register fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_OP_W     = 3;
  localparam int CTRL_ADDR_LSB = 8;

  // Operation codes written to the command register
  localparam logic [2:0] OP_ROT_MEM   = 3'h0;
  localparam logic [2:0] OP_ROT_ACC   = 3'h1;
  localparam logic [2:0] OP_ROTC_MEM  = 3'h2;
  localparam logic [2:0] OP_ROTC_ACC  = 3'h3;
  localparam logic [2:0] OP_SUB_ACC   = 3'h4;
  localparam logic [2:0] OP_SUB_MEM   = 3'h5;
  localparam logic [2:0] OP_LAST      = 3'h5;

  // Status flag bit positions
  localparam int FLAG_W = 6;
  localparam int FLG_C  = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_SC = 4;
  localparam int FLG_CZ = 5;

  // Values after reset
  localparam logic [7:0]        ACC_RST  = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RST = 6'h00;
  localparam logic [7:0]        MEM_RST  = 8'h00;

endpackage

// *** rtl/rotate_unit.sv ***
module rotate_unit (
  // Operand
  input  wire logic [7:0] data_in,
  input  wire logic       carry_in,
  input  wire logic       thru_carry,
  // Result
  output logic      [7:0] data_out,
  output logic            carry_out
);

  // Bit 0 leaves on the right; bit 7 refills from bit 0 or from carry
  always_comb begin
    data_out  = {(thru_carry ? carry_in : data_in[0]), data_in[7:1]};
    carry_out = thru_carry ? data_in[0] : carry_in;
  end

endmodule

// *** rtl/sub_borrow_unit.sv ***
module sub_borrow_unit (
  // Operands
  input  wire logic [7:0] acc_in,
  input  wire logic [7:0] mem_in,
  input  wire logic       carry_in,
  input  wire logic       cz_in,
  // Difference and flags
  output logic      [7:0] diff,
  output logic            carry_out,
  output logic            aux_carry_out,
  output logic            zero_out,
  output logic            overflow_out,
  output logic            signed_cmp_out,
  output logic            comb_zero_out
);

  logic [8:0] wide;
  logic [4:0] low;

  always_comb begin
    // Borrow in is the inverted carry
    wide = {1'b0, acc_in} - {1'b0, mem_in} - {8'h00, ~carry_in};
    low  = {1'b0, acc_in[3:0]} - {1'b0, mem_in[3:0]} - {4'h0, ~carry_in};
    diff = wide[7:0];
    // Carry means no borrow: result zero or positive
    carry_out      = ~wide[8];
    aux_carry_out  = ~low[4];
    zero_out       = (wide[7:0] == 8'h00);
    overflow_out   = (acc_in[7] ^ mem_in[7]) & (acc_in[7] ^ wide[7]);
    signed_cmp_out = overflow_out ^ wide[7];
    // Zero only if this byte and the earlier chain were zero
    comb_zero_out  = zero_out & cz_in;
  end

endmodule

// *** rtl/alu_top.sv ***
// Overview of operation
// - Memory rotate right, bit0 to bit7, no flags
// - Rotated byte to accumulator, memory and flags kept
// - Nine-bit ring rotate in memory, carry only
// - Nine-bit ring rotate into accumulator, carry only
// - Accumulator gets acc minus mem minus not-carry
// - Carry cleared if negative, set otherwise
// - Subtract updates six arithmetic flags only
// - Subtract difference to memory, accumulator kept
//
// The placing of the registers and register access over APB are this design's own decisions.
module alu_top #(
  parameter int MEM_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import alu_pkg::*;

  localparam int ADDR_W = $clog2(MEM_DEPTH);

  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [7:0]                acc;
    logic [FLAG_W-1:0]         flags;
    logic [ADDR_W-1:0]         maddr;
    logic [ADDR_W-1:0]         xaddr;
    logic [2:0]                op;
    logic                      busy;
    logic                      cap_ok;
    logic [31:0]               rdata;
  } state_t;

  state_t            st_r;
  state_t            st_nxt;
  logic [7:0]        cur_m;
  logic              thru_c;
  logic [7:0]        rot_res;
  logic              rot_c;
  logic [7:0]        sub_res;
  logic              sub_c;
  logic              sub_ac;
  logic              sub_z;
  logic              sub_ov;
  logic              sub_sc;
  logic              sub_cz;
  logic [31:0]       rd_mux;
  logic              mapped;
  logic              bad_op;
  logic              xfer_done;
  logic              wr_ok;
  logic [FLAG_W-1:0] sub_flags;
  logic [7:0]        exp_diff;

  assign cur_m  = st_r.mem[st_r.xaddr];
  assign thru_c = (st_r.op == OP_ROTC_MEM) || (st_r.op == OP_ROTC_ACC);

  rotate_unit u_rot (
    .data_in   (cur_m),
    .carry_in  (st_r.flags[FLG_C]),
    .thru_carry(thru_c),
    .data_out  (rot_res),
    .carry_out (rot_c)
  );

  sub_borrow_unit u_sub (
    .acc_in        (st_r.acc),
    .mem_in        (cur_m),
    .carry_in      (st_r.flags[FLG_C]),
    .cz_in         (st_r.flags[FLG_CZ]),
    .diff          (sub_res),
    .carry_out     (sub_c),
    .aux_carry_out (sub_ac),
    .zero_out      (sub_z),
    .overflow_out  (sub_ov),
    .signed_cmp_out(sub_sc),
    .comb_zero_out (sub_cz)
  );

  // Bus decode
  always_comb begin
    mapped = (paddr == CTRL_OFF) || (paddr == ACC_OFF) ||
             (paddr == FLAG_OFF) || (paddr == MADDR_OFF) ||
             (paddr == MDATA_OFF);
    bad_op = pwrite && (paddr == CTRL_OFF) &&
             (pwdata[CTRL_OP_LSB +: CTRL_OP_W] > OP_LAST);
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFF: begin
        rd_mux[CTRL_OP_LSB +: CTRL_OP_W] = st_r.op;
        rd_mux[CTRL_ADDR_LSB +: ADDR_W]  = st_r.xaddr;
      end
      ACC_OFF:   rd_mux[7:0]          = st_r.acc;
      FLAG_OFF:  rd_mux[FLAG_W-1:0]   = st_r.flags;
      MADDR_OFF: rd_mux[ADDR_W-1:0]   = st_r.maddr;
      MDATA_OFF: rd_mux[7:0]          = st_r.mem[st_r.maddr];
      default:   rd_mux               = 32'h0000_0000;
    endcase
  end

  // Read data is sampled one cycle early so prdata comes from a flop;
  // the access waits while an operation executes.
  assign pready    = psel && penable && st_r.cap_ok && !st_r.busy;
  assign pslverr   = pready && (!mapped || bad_op);
  assign prdata    = st_r.rdata;
  assign xfer_done = pready;
  assign wr_ok     = xfer_done && pwrite && mapped && !bad_op;

  always_comb begin
    sub_flags         = st_r.flags;
    sub_flags[FLG_C]  = sub_c;
    sub_flags[FLG_AC] = sub_ac;
    sub_flags[FLG_Z]  = sub_z;
    sub_flags[FLG_OV] = sub_ov;
    sub_flags[FLG_SC] = sub_sc;
    sub_flags[FLG_CZ] = sub_cz;
  end

  always_comb begin
    st_nxt        = st_r;
    st_nxt.busy   = 1'b0;
    st_nxt.cap_ok = psel && !st_r.busy && !xfer_done;
    if (psel) begin
      st_nxt.rdata = rd_mux;
    end
    if (st_r.busy) begin
      unique case (st_r.op)
        OP_ROT_MEM: st_nxt.mem[st_r.xaddr] = rot_res;
        OP_ROT_ACC: st_nxt.acc = rot_res;
        OP_ROTC_MEM: begin
          st_nxt.mem[st_r.xaddr]  = rot_res;
          st_nxt.flags[FLG_C]     = rot_c;
        end
        OP_ROTC_ACC: begin
          st_nxt.acc          = rot_res;
          st_nxt.flags[FLG_C] = rot_c;
        end
        OP_SUB_ACC: begin
          st_nxt.acc   = sub_res;
          st_nxt.flags = sub_flags;
        end
        OP_SUB_MEM: begin
          st_nxt.mem[st_r.xaddr] = sub_res;
          st_nxt.flags           = sub_flags;
        end
        default: ;
      endcase
    end
    if (wr_ok) begin
      unique case (paddr)
        CTRL_OFF: begin
          st_nxt.op    = pwdata[CTRL_OP_LSB +: CTRL_OP_W];
          st_nxt.xaddr = pwdata[CTRL_ADDR_LSB +: ADDR_W];
          st_nxt.busy  = 1'b1;
        end
        ACC_OFF:   st_nxt.acc   = pwdata[7:0];
        FLAG_OFF:  st_nxt.flags = pwdata[FLAG_W-1:0];
        MADDR_OFF: st_nxt.maddr = pwdata[ADDR_W-1:0];
        MDATA_OFF: st_nxt.mem[st_r.maddr] = pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.mem    <= {MEM_DEPTH{MEM_RST}};
      st_r.acc    <= ACC_RST;
      st_r.flags  <= FLAG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Reference difference, kept apart from the subtract unit
  assign exp_diff = 8'(st_r.acc - cur_m - {7'h00, ~st_r.flags[FLG_C]});

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_rot_mem_byte: assert property (
    st_r.busy && st_r.op == OP_ROT_MEM |=>
      st_r.mem[$past(st_r.xaddr)] == {$past(cur_m[0]), $past(cur_m[7:1])}
      && $stable(st_r.flags) && $stable(st_r.acc))
    else $error("rotate right in memory wrong");

  a_rot_acc_val: assert property (
    st_r.busy && st_r.op == OP_ROT_ACC |=>
      st_r.acc == {$past(cur_m[0]), $past(cur_m[7:1])}
      && $stable(st_r.mem) && $stable(st_r.flags))
    else $error("rotate right to accumulator wrong");

  a_ring_mem_byte: assert property (
    st_r.busy && st_r.op == OP_ROTC_MEM |=>
      st_r.mem[$past(st_r.xaddr)] ==
        {$past(st_r.flags[FLG_C]), $past(cur_m[7:1])}
      && st_r.flags[FLG_C] == $past(cur_m[0])
      && st_r.flags[FLAG_W-1:1] == $past(st_r.flags[FLAG_W-1:1]))
    else $error("ring rotate in memory wrong");

  a_ring_acc_val: assert property (
    st_r.busy && st_r.op == OP_ROTC_ACC |=>
      st_r.acc == {$past(st_r.flags[FLG_C]), $past(cur_m[7:1])}
      && st_r.flags[FLG_C] == $past(cur_m[0])
      && $stable(st_r.mem)
      && st_r.flags[FLAG_W-1:1] == $past(st_r.flags[FLAG_W-1:1]))
    else $error("ring rotate to accumulator wrong");

  a_sub_acc_val: assert property (
    st_r.busy && st_r.op == OP_SUB_ACC |=>
      st_r.acc == $past(exp_diff) && $stable(st_r.mem))
    else $error("subtract to accumulator wrong");

  a_sub_carry: assert property (
    st_r.busy && (st_r.op == OP_SUB_ACC || st_r.op == OP_SUB_MEM) |=>
      st_r.flags[FLG_C] == ($past(st_r.acc) >=
        $past(cur_m) + ($past(st_r.flags[FLG_C]) ? 0 : 1)))
    else $error("subtract carry wrong");

  a_sub_aux_flags: assert property (
    st_r.busy && st_r.op == OP_SUB_ACC |=>
      st_r.flags[FLG_SC] == (st_r.flags[FLG_OV] ^ st_r.acc[7])
      && st_r.flags[FLG_CZ] ==
        (st_r.flags[FLG_Z] & $past(st_r.flags[FLG_CZ])))
    else $error("subtract flag set wrong");

  a_sub_mem_val: assert property (
    st_r.busy && st_r.op == OP_SUB_MEM |=>
      st_r.mem[$past(st_r.xaddr)] == $past(exp_diff)
      && $stable(st_r.acc))
    else $error("subtract to memory wrong");

  a_sub_zero_ov: assert property (
    st_r.busy && (st_r.op == OP_SUB_ACC || st_r.op == OP_SUB_MEM) |=>
      st_r.flags[FLG_Z] == ($past(exp_diff) == 8'h00)
      && st_r.flags[FLG_OV] ==
        (($past(st_r.acc[7]) != $past(cur_m[7]))
         && ($past(exp_diff[7]) != $past(st_r.acc[7]))))
    else $error("zero or overflow flag wrong");

  // Execution lasts one cycle and holds off the bus
  a_exec_one_cycle: assert property (
    st_r.busy |-> !pready ##1 !st_r.busy)
    else $error("execution not single cycle");

  a_sub_aux_carry: assert property (
    st_r.busy && (st_r.op == OP_SUB_ACC || st_r.op == OP_SUB_MEM) |=>
      st_r.flags[FLG_AC] == ($past(st_r.acc[3:0]) >=
        $past(cur_m[3:0]) + ($past(st_r.flags[FLG_C]) ? 0 : 1)))
    else $error("subtract aux carry wrong");

  // Memory form signed and chain flags
  a_sub_mem_flags: assert property (
    st_r.busy && st_r.op == OP_SUB_MEM |=>
      st_r.flags[FLG_SC] ==
        (st_r.flags[FLG_OV] ^ st_r.mem[$past(st_r.xaddr)][7])
      && st_r.flags[FLG_CZ] ==
        (st_r.flags[FLG_Z] & $past(st_r.flags[FLG_CZ])))
    else $error("subtract to memory flag set wrong");

  // Refused access must leave accumulator, flags, memory and maddr alone and start no execution
  a_refused_no_effect: assert property (
    pready && pslverr |=>
      !st_r.busy && $stable(st_r.acc) && $stable(st_r.flags)
      && $stable(st_r.mem) && $stable(st_r.maddr))
    else $error("refused access changed state");

  // Accepted command write starts execution
  a_ctrl_starts: assert property (
    pready && pwrite && paddr == CTRL_OFF && !pslverr |=>
      st_r.busy && st_r.op == $past(pwdata[CTRL_OP_LSB +: CTRL_OP_W]))
    else $error("command write did not start");

endmodule

// *** test/alu_top_bench.sv ***
module alu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import alu_pkg::*;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  int          miscompares = 0;
  int          check_count = 0;
  logic        no_gap      = 1'b0;
  logic [31:0] exp_wait    = 32'h0000_0000;

  // Rows are accumulator, memory byte, flags before the subtract
  logic [21:0] sub_tab [6] = '{
    {8'h50, 8'h30, 6'h01}, {8'h30, 8'h30, 6'h21}, {8'h30, 8'h30, 6'h00},
    {8'h80, 8'h01, 6'h01}, {8'h7f, 8'hff, 6'h01}, {8'h10, 8'h01, 6'h3e}};
  logic [7:0]  offs [5] = '{ACC_OFF, FLAG_OFF, MADDR_OFF, MDATA_OFF, CTRL_OFF};

  alu_top #(.MEM_DEPTH(16)) uut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  task automatic test_done;
    $display("checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // Entered just after a rising edge; leaves one idle cycle behind it
  // unless no_gap asks for the next setup cycle at once
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic exp_err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("wait states", exp_wait, 32'(n - 1));
    chk("pslverr", 32'(exp_err), 32'(pslverr));
    rdat = prdata;
    if (!no_gap) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000, 1'b0);
  endtask

  task automatic run_chk(input logic [2:0] op, input logic [3:0] adr,
                         input logic [7:0] m, input logic [7:0] a,
                         input logic [5:0] f, input logic [7:0] em,
                         input logic [7:0] ea, input logic [5:0] ef);
    wr(MADDR_OFF, 32'(adr));
    wr(MDATA_OFF, 32'(m));
    wr(ACC_OFF, 32'(a));
    wr(FLAG_OFF, 32'(f));
    wr(CTRL_OFF, 32'(op) | (32'(adr) << CTRL_ADDR_LSB));
    rd(MDATA_OFF);
    chk("mem", 32'(em), rdat);
    rd(ACC_OFF);
    chk("acc", 32'(ea), rdat);
    rd(FLAG_OFF);
    chk("flags", 32'(ef), rdat);
    rd(CTRL_OFF);
    chk("ctrl", 32'(op) | (32'(adr) << CTRL_ADDR_LSB), rdat);
  endtask

  // Result byte and all six flags, worked out bit by bit
  function automatic logic [13:0] sub_ref(input logic [7:0] a,
                                          input logic [7:0] m,
                                          input logic [5:0] f);
    logic [8:0] d;
    logic [4:0] lo;
    logic [5:0] fl;
    d  = {1'b0, a} - {1'b0, m} - 9'(!f[FLG_C]);
    lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - 5'(!f[FLG_C]);
    fl = 6'h00;
    fl[FLG_C]  = !d[8];
    fl[FLG_AC] = !lo[4];
    fl[FLG_Z]  = (d[7:0] == 8'h00);
    fl[FLG_OV] = (a[7] != m[7]) && (d[7] != a[7]);
    fl[FLG_SC] = fl[FLG_OV] ^ d[7];
    fl[FLG_CZ] = fl[FLG_Z] & f[FLG_CZ];
    return {d[7:0], fl};
  endfunction

  initial begin
    logic [7:0]  a;
    logic [7:0]  m;
    logic [5:0]  f;
    logic [13:0] r;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset value", 32'h0000_0000, rdat);
    end
    run_chk(OP_ROT_MEM, 4'h3, 8'h81, 8'h5a, 6'h3e,
            8'hc0, 8'h5a, 6'h3e);
    run_chk(OP_ROT_MEM, 4'hf, 8'h02, 8'h00, 6'h01,
            8'h01, 8'h00, 6'h01);
    run_chk(OP_ROT_ACC, 4'h5, 8'h03, 8'h00, 6'h15,
            8'h03, 8'h81, 6'h15);
    run_chk(OP_ROTC_MEM, 4'h1, 8'h01, 8'h11, 6'h3e,
            8'h00, 8'h11, 6'h3f);
    run_chk(OP_ROTC_MEM, 4'h2, 8'h80, 8'h11, 6'h01,
            8'hc0, 8'h11, 6'h00);
    run_chk(OP_ROTC_ACC, 4'h7, 8'h02, 8'h00, 6'h21,
            8'h02, 8'h81, 6'h20);
    run_chk(OP_ROTC_ACC, 4'h8, 8'hff, 8'h00, 6'h00,
            8'hff, 8'h7f, 6'h01);
    foreach (sub_tab[i]) begin
      {a, m, f} = sub_tab[i];
      r = sub_ref(a, m, f);
      run_chk(OP_SUB_ACC, 4'(i), m, a, f,
              m, r[13:6], r[5:0]);
      run_chk(OP_SUB_MEM, 4'(i + 9), m, a,
              f, r[13:6], a, r[5:0]);
    end
    // A read set up in the execution cycle waits one cycle
    wr(MADDR_OFF, 32'h0000_0004);
    wr(MDATA_OFF, 32'h0000_0003);
    no_gap = 1'b1;
    wr(CTRL_OFF, 32'h0000_0401);
    no_gap   = 1'b0;
    exp_wait = 32'h0000_0001;
    rd(ACC_OFF);
    exp_wait = 32'h0000_0000;
    chk("acc read in exec cycle", 32'h0000_0081, rdat);
    // Upper bits are dropped on write and read back as zero
    wr(ACC_OFF, 32'hffff_ff12);
    rd(ACC_OFF);
    chk("acc low byte", 32'h0000_0012, rdat);
    xfer(1'b1, CTRL_OFF, 32'h0000_0107, 1'b1);
    xfer(1'b1, CTRL_OFF, 32'h0000_0206, 1'b1);
    rd(ACC_OFF);
    chk("acc after refused op", 32'h0000_0012, rdat);
    xfer(1'b0, 8'h14, 32'h0000_0000, 1'b1);
    chk("unmapped read", 32'h0000_0000, rdat);
    xfer(1'b1, 8'h40, 32'h0000_00aa, 1'b1);
    test_done;
  end

  // Whole run is near 570 cycles; this limit is about 35 times that
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done;
  end
endmodule
